// ### logic/gptb_top.sv
// Second timer block with AHB-Lite register slave
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "gptb_defs.svh"
module gptb_top (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        aux_dir_pin_i,
	input  wire logic        core_dir_pin_i,
	input  wire logic        capture_input_pin_i,
	input  wire logic        first_block_count_input_i,
	input  wire logic        first_block_direction_input_i,
	output logic             toggle_output_pin_o,
	output logic             capcom_clk_o,
	output logic             aux_irq_o,
	output logic             core_irq_o,
	output logic             cap_irq_o
);
	logic [31:0]         ctrl;
	gptb_pkg::gptb_tmr_type aux_timer;
	gptb_pkg::gptb_tmr_type core_timer;
	gptb_pkg::gptb_tmr_type capture_reload_reg;
	logic                overflow_toggle_latch;
	logic [2:0]          flags;
	logic                cap_d;
	logic                cnt_d;
	logic                dir_d;
	logic                otl_d;
	logic                wr_pend;
	logic [7:0]          wr_addr;
	logic                wr_aux;
	logic                wr_core;
	logic                wr_cap;
	logic                wr_stat;
	logic [15:0]         aux_nx;
	logic [15:0]         core_nx;
	logic                aux_wrap;
	logic                core_wrap;
	logic                aux_down;
	logic                core_down;
	logic                aux_tick;
	logic                core_tick;
	logic                core_evt;
	logic                aux_evt;
	logic                cap_evt;
	logic                cap_pin_edge;
	logic                cnt_edge;
	logic                dir_edge;
	gptb_pkg::gptb_edge_type   cap_sel;
	gptb_pkg::gptb_capsrc_type src_sel;
	logic                access;

	function automatic logic edge_hit(input logic now, input logic was, input gptb_pkg::gptb_edge_type sel);
		edge_hit = ((sel == gptb_pkg::gptb_edge_rise || sel == gptb_pkg::gptb_edge_both) && now && !was)
		        || ((sel == gptb_pkg::gptb_edge_fall || sel == gptb_pkg::gptb_edge_both) && !now && was);
	endfunction : edge_hit

	assign cap_sel   = gptb_pkg::gptb_edge_type'(ctrl[`GPTB_C_CAPEDGE_LO +: 2]);
	assign src_sel   = gptb_pkg::gptb_capsrc_type'(ctrl[`GPTB_C_CAPSRC_LO +: 2]);
	assign aux_down  = ctrl[`GPTB_C_AUX_DOWN] ^ (ctrl[`GPTB_C_AUX_EUD] & aux_dir_pin_i);
	assign core_down = ctrl[`GPTB_C_CORE_DOWN] ^ (ctrl[`GPTB_C_CORE_EUD] & core_dir_pin_i);
	assign core_tick = ctrl[`GPTB_C_CORE_RUN];
	assign aux_tick  = ctrl[`GPTB_C_AUX_RUN] & (ctrl[`GPTB_C_AUX_CHAIN] ?
	                   (overflow_toggle_latch != otl_d) : 1'b1);
	assign core_evt  = core_tick & core_wrap;
	assign aux_evt   = aux_tick & aux_wrap;
	assign cap_pin_edge = edge_hit(capture_input_pin_i, cap_d, cap_sel);
	assign cnt_edge  = first_block_count_input_i ^ cnt_d;
	assign dir_edge  = first_block_direction_input_i ^ dir_d;
	always_comb begin
		unique case (src_sel)
			gptb_pkg::gptb_src_pin:    cap_evt = cap_pin_edge;
			gptb_pkg::gptb_src_cnt:    cap_evt = cnt_edge;
			gptb_pkg::gptb_src_dir:    cap_evt = dir_edge;
			gptb_pkg::gptb_src_cntdir: cap_evt = cnt_edge | dir_edge;
		endcase
	end

	gptb_step u_aux (
		.value_i      (aux_timer),
		.down_i       (aux_down),
		.next_value_o (aux_nx),
		.wrap_o       (aux_wrap)
	);
	gptb_step u_core (
		.value_i      (core_timer),
		.down_i       (core_down),
		.next_value_o (core_nx),
		.wrap_o       (core_wrap)
	);

	// Bus slave, zero wait states
	assign access  = hsel_i & hready_i & (htrans_i == `GPTB_HTRANS_NONSEQ);
	assign wr_aux  = wr_pend & (wr_addr == `GPTB_ADDR_AUX);
	assign wr_core = wr_pend & (wr_addr == `GPTB_ADDR_CORE);
	assign wr_cap  = wr_pend & (wr_addr == `GPTB_ADDR_CAPTURE_RELOAD_REG);
	assign wr_stat = wr_pend & (wr_addr == `GPTB_ADDR_STATUS);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= access & hwrite_i;
			wr_addr <= haddr_i[`GPTB_ADDR_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			hrdata_o <= 32'h0000_0000;
		end else if (access & !hwrite_i) begin
			unique case (haddr_i[`GPTB_ADDR_W-1:0])
				`GPTB_ADDR_CTRL:   hrdata_o <= ctrl;
				`GPTB_ADDR_STATUS: hrdata_o <= {28'h0000000, overflow_toggle_latch, flags};
				`GPTB_ADDR_AUX:    hrdata_o <= {16'h0000, aux_timer};
				`GPTB_ADDR_CORE:   hrdata_o <= {16'h0000, core_timer};
				`GPTB_ADDR_CAPTURE_RELOAD_REG: hrdata_o <= {16'h0000, capture_reload_reg};
				default:           hrdata_o <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			ctrl <= `GPTB_CTRL_RESET;
		else if (wr_pend && wr_addr == `GPTB_ADDR_CTRL)
			ctrl <= {18'h00000, hwdata_i[13:0]};
	end

	// Edge history
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cap_d <= 1'b0;
			cnt_d <= 1'b0;
			dir_d <= 1'b0;
			otl_d <= 1'b0;
		end else begin
			cap_d <= capture_input_pin_i;
			cnt_d <= first_block_count_input_i;
			dir_d <= first_block_direction_input_i;
			otl_d <= overflow_toggle_latch;
		end
	end

	// Core timer
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			core_timer <= `GPTB_TMR_ZERO;
		else if (wr_core)
			core_timer <= hwdata_i[15:0];
		else if (core_evt && ctrl[`GPTB_C_RELOAD])
			core_timer <= capture_reload_reg;
		else if (core_tick)
			core_timer <= core_nx;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			overflow_toggle_latch <= 1'b0;
		else if (core_evt)
			overflow_toggle_latch <= ~overflow_toggle_latch;
	end

	// Aux timer
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			aux_timer <= `GPTB_TMR_ZERO;
		else if (wr_aux)
			aux_timer <= hwdata_i[15:0];
		else if (cap_evt && ctrl[`GPTB_C_CLRCAP])
			aux_timer <= `GPTB_TMR_ZERO;
		else if (aux_tick)
			aux_timer <= aux_nx;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			capture_reload_reg <= `GPTB_TMR_ZERO;
		else if (cap_evt)
			capture_reload_reg <= aux_timer;
		else if (wr_cap)
			capture_reload_reg <= hwdata_i[15:0];
	end

	// Request flags; set wins over clear
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			flags <= 3'h0;
		else
			flags <= (flags & ~(wr_stat ? hwdata_i[2:0] : 3'h0)) | {cap_evt, core_evt, aux_evt};
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			toggle_output_pin_o <= 1'b0;
			capcom_clk_o        <= 1'b0;
			aux_irq_o           <= 1'b0;
			core_irq_o          <= 1'b0;
			cap_irq_o           <= 1'b0;
		end else begin
			toggle_output_pin_o <= ctrl[`GPTB_C_TOGOUT] & overflow_toggle_latch;
			capcom_clk_o        <= core_evt;
			aux_irq_o           <= flags[`GPTB_S_AUX_IR];
			core_irq_o          <= flags[`GPTB_S_CORE_IR];
			cap_irq_o           <= flags[`GPTB_S_CAP_IR];
		end
	end
endmodule : gptb_top

// ### logic/gptb_defs.svh
// Constants and rule summary for the second timer block
// How it works
// - Up/down by software, direction pin may invert it
// - Toggle latch inverts on core over/underflow
// - Toggle latch can clock auxiliary timer
// - Toggle latch driven onto toggle pin
// - Core over/underflow offered as capcom clock
// - Reload core timer from capture register
// - Selected capture pin edge captures aux timer
// - Optionally clear aux timer after capture
// - Capture may come from first-block inputs
`ifndef GPTB_DEFS_SVH
`define GPTB_DEFS_SVH
`define GPTB_ADDR_CTRL    8'h00
`define GPTB_ADDR_STATUS  8'h04
`define GPTB_ADDR_AUX     8'h08
`define GPTB_ADDR_CORE    8'h0C
`define GPTB_ADDR_CAPTURE_RELOAD_REG  8'h10
`define GPTB_ADDR_W       8
`define GPTB_TMR_W        16
`define GPTB_TMR_MAX      16'hFFFF
`define GPTB_TMR_ZERO     16'h0000
`define GPTB_CTRL_RESET   32'h0000_0000
`define GPTB_HTRANS_NONSEQ 2'h2
// Control fields
`define GPTB_C_AUX_RUN    0
`define GPTB_C_AUX_DOWN   1
`define GPTB_C_AUX_EUD    2
`define GPTB_C_AUX_CHAIN  3
`define GPTB_C_CORE_RUN   4
`define GPTB_C_CORE_DOWN  5
`define GPTB_C_CORE_EUD   6
`define GPTB_C_RELOAD     7
`define GPTB_C_TOGOUT     8
`define GPTB_C_CLRCAP     9
`define GPTB_C_CAPEDGE_LO 10
`define GPTB_C_CAPSRC_LO  12
// Status bits
`define GPTB_S_AUX_IR     0
`define GPTB_S_CORE_IR    1
`define GPTB_S_CAP_IR     2
`define GPTB_S_OTL        3
`endif

// ### logic/gptb_pkg.sv
// Types for the second timer block
`include "gptb_defs.svh"
package gptb_pkg;
	typedef enum logic [1:0] {gptb_edge_none, gptb_edge_rise, gptb_edge_fall, gptb_edge_both} gptb_edge_type;
	typedef enum logic [1:0] {gptb_src_pin, gptb_src_cnt, gptb_src_dir, gptb_src_cntdir} gptb_capsrc_type;
	typedef logic [`GPTB_TMR_W-1:0] gptb_tmr_type;
endpackage : gptb_pkg

// ### logic/gptb_step.sv
// One up/down counter step with wrap detection
`timescale 1ns/100ps
`include "gptb_defs.svh"
module gptb_step (
	input  wire logic [15:0] value_i,
	input  wire logic        down_i,
	output logic      [15:0] next_value_o,
	output logic             wrap_o
);
	always_comb begin
		if (down_i) begin
			next_value_o = value_i - 16'h0001;
			wrap_o       = (value_i == `GPTB_TMR_ZERO);
		end else begin
			next_value_o = value_i + 16'h0001;
			wrap_o       = (value_i == `GPTB_TMR_MAX);
		end
	end
endmodule : gptb_step

// ### test/gptb_sva.sv
// Port checker for the second timer block
`timescale 1ns/100ps
module gptb_sva (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic hsel_i,
	input wire logic capture_input_pin_i,
	input wire logic first_block_count_input_i,
	input wire logic first_block_direction_input_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic toggle_output_pin_o,
	input wire logic capcom_clk_o,
	input wire logic aux_irq_o,
	input wire logic core_irq_o,
	input wire logic cap_irq_o
);
	logic [2:0] ins;
	logic [2:0] sel_q;
	assign ins = {capture_input_pin_i, first_block_count_input_i, first_block_direction_input_i};
	// Bus selects one, two and three cycles back
	always_ff @(posedge clk_i) begin
		sel_q <= {sel_q[1:0], hsel_i};
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	chk_bus_okay: assert property (hreadyout_o && !hresp_o) else $error("bus not okay");
	chk_capcom_flag: assert property (capcom_clk_o |=> core_irq_o) else $error("capcom");
	chk_core_rise: assert property ($rose(core_irq_o) |-> $past(capcom_clk_o)) else $error("core");
	chk_toggle_cause: assert property ($changed(toggle_output_pin_o) |-> $past(capcom_clk_o) || sel_q[2])
		else $error("toggle");
	chk_toggle_flip: assert property (capcom_clk_o && toggle_output_pin_o
		|=> !toggle_output_pin_o) else $error("flip");
	chk_cap_cause: assert property ($rose(cap_irq_o) |-> $past(ins, 2) != $past(ins, 3))
		else $error("capture");
	chk_flag_sticky: assert property ($fell(aux_irq_o) || $fell(core_irq_o) || $fell(cap_irq_o)
		|-> sel_q[2]) else $error("sticky");
	chk_reset_quiet: assert property (disable iff (1'h0) sys_rst_i |=> hreadyout_o && !toggle_output_pin_o
		&& !capcom_clk_o && !aux_irq_o && !core_irq_o && !cap_irq_o) else $error("reset");
endmodule : gptb_sva
bind gptb_top gptb_sva gptb_sva_inst (.clk_i, .sys_rst_i, .hsel_i, .capture_input_pin_i, .first_block_count_input_i,
	.first_block_direction_input_i, .hreadyout_o, .hresp_o, .toggle_output_pin_o, .capcom_clk_o, .aux_irq_o,
	.core_irq_o, .cap_irq_o);

// ### test/gptb_pins.sv
// Pin side model: capture, first block and direction pins
`timescale 1ns/100ps
module gptb_pins (
	input  wire logic       clk_i,
	output logic      [4:0] pin_o
);
	initial pin_o = 5'h00;
	task set(input logic [4:0] v);
		@(posedge clk_i);
		pin_o <= v;
	endtask : set
endmodule : gptb_pins

// ### test/tb_gp_timer_block_two_capture_reload.sv
// Bench for the second timer block
`timescale 1ns/100ps
module tb_gp_timer_block_two_capture_reload;
	logic        clk_i, sys_rst_i, hsel_i, hwrite_i, tog_q;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
	logic [1:0]  htrans_i;
	logic [4:0]  pin;
	logic        hreadyout_o, hresp_o, toggle_output_pin_o, capcom_clk_o, aux_irq_o, core_irq_o, cap_irq_o;
	int          num_errors, samples_checked, pulses, flips;
	gptb_top gptb_top_inst (.clk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
		.hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .aux_dir_pin_i(pin[3]),
		.core_dir_pin_i(pin[4]), .capture_input_pin_i(pin[0]), .first_block_count_input_i(pin[1]),
		.first_block_direction_input_i(pin[2]), .toggle_output_pin_o, .capcom_clk_o, .aux_irq_o,
		.core_irq_o, .cap_irq_o);
	gptb_pins gptb_pins_inst (.clk_i, .pin_o(pin));
	initial begin
		clk_i = 1'h0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(negedge clk_i) begin
		pulses += capcom_clk_o === 1'h1;
		flips += toggle_output_pin_o !== tog_q;
		tog_q = toggle_output_pin_o;
	end
	task check(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel_i <= 1'h1;
		haddr_i <= {24'h0, a};
		htrans_i <= 2'h2;
		hwrite_i <= w;
		do @(posedge clk_i); while (hreadyout_o !== 1'h1);
		hsel_i <= 1'h0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge clk_i); while (hreadyout_o !== 1'h1);
		rd = hrdata_o;
	endtask : bus
	task idle;
		bus(1'h1, 8'h00, 32'h0);
		bus(1'h1, 8'h04, 32'h7);
	endtask : idle
	task t_reset;
		bus(1'h1, 8'h14, 32'hFFFF_FFFF);
		for (int a = 0; a < 24; a += 4) begin
			bus(1'h0, a[7:0], 32'h0);
			check("reset read", rd, 32'h0);
		end
	endtask : t_reset
	task t_core(input logic [31:0] c, input logic [31:0] v, input logic [4:0] p, input int n);
		int p0, q0, f0;
		bus(1'h1, 8'h10, v);
		bus(1'h1, 8'h0C, v);
		bus(1'h1, 8'h08, 32'h0);
		gptb_pins_inst.set(p);
		p0 = pulses;
		bus(1'h1, 8'h00, c);
		repeat (4) @(posedge clk_i);
		q0 = pulses;
		f0 = flips;
		repeat (20) @(posedge clk_i);
		check("pulses", pulses - q0, n);
		check("flips", flips - f0, n);
		check("core flag", {31'h0, core_irq_o}, {31'h0, n != 0});
		bus(1'h1, 8'h00, c & 32'hFFFF_FFEF);
		repeat (3) @(posedge clk_i);
		bus(1'h0, 8'h08, 32'h0);
		check("chained aux", rd, pulses - p0);
		idle;
	endtask : t_core
	task t_cap(input logic [31:0] c, input logic [4:0] m, input logic [31:0] e);
		bus(1'h1, 8'h10, 32'h1234);
		bus(1'h1, 8'h00, c);
		gptb_pins_inst.set(m);
		repeat (4) @(posedge clk_i);
		gptb_pins_inst.set(5'h00);
		repeat (4) @(posedge clk_i);
		gptb_pins_inst.set(m);
		repeat (2) @(posedge clk_i);
		gptb_pins_inst.set(5'h00);
		repeat (3) @(posedge clk_i);
		bus(1'h0, 8'h10, 32'h0);
		check("capture", rd, e);
		check("cap flag", {31'h0, cap_irq_o}, {31'h0, e != 32'h1234});
		idle;
	endtask : t_cap
	task t_aux;
		bus(1'h1, 8'h08, 32'hFFFE);
		gptb_pins_inst.set(5'h08);
		check("aux flag idle", {31'h0, aux_irq_o}, 32'h0);
		bus(1'h1, 8'h00, 32'h7);
		repeat (4) @(posedge clk_i);
		check("aux flag", {31'h0, aux_irq_o}, 32'h1);
		bus(1'h0, 8'h04, 32'h0);
		check("aux status", rd & 32'h7, 32'h1);
		idle;
		bus(1'h0, 8'h04, 32'h0);
		check("flags cleared", rd & 32'h7, 32'h0);
		gptb_pins_inst.set(5'h00);
	endtask : t_aux
	task final_report;
		$display("Checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (5000) @(posedge clk_i);
		num_errors++;
		final_report;
	end
	initial begin
		sys_rst_i = 1'h1;
		hsel_i = 1'h0;
		haddr_i = 32'h0;
		htrans_i = 2'h0;
		hwrite_i = 1'h0;
		hwdata_i = 32'h0;
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'h0;
		t_reset;
		t_core(32'h199, 32'hFFFE, 5'h00, 10);
		t_core(32'h1B9, 32'h0001, 5'h00, 10);
		t_core(32'h1F9, 32'h0001, 5'h10, 0);
		t_core(32'h1D9, 32'hFFFE, 5'h10, 0);
		t_cap(32'h201, 5'h01, 32'h1234);
		t_cap(32'h601, 5'h01, 32'h9);
		t_cap(32'hA01, 5'h01, 32'h7);
		t_cap(32'hE01, 5'h01, 32'h2);
		t_cap(32'h1E01, 5'h02, 32'h2);
		t_cap(32'h2E01, 5'h04, 32'h2);
		t_cap(32'h3E01, 5'h02, 32'h2);
		t_aux;
		final_report;
	end
endmodule : tb_gp_timer_block_two_capture_reload
